// ===== rtl/ulm_link.sv
// ULPI link controller for suspend, interface protection and serial modes
// Function
// - Link sets fast start-up enable before a power-management suspend.
// - Link drives bus while direction low; one turnaround cycle per change.
// - Link holds stop high until its own start-up completes.
// - Link drives idle after turnaround; non-idle is taken as transmit.
// - Link leaves reset with stop high and data bus released.
// - Link driving stop high in reset may disable the pull-up.
// - Undriven stop pulled high acts as wake request to PHY.
// - Link clears ID-open enables in low power; with CFG_HOST_OTG set, re-enables comparators after.
// - Link enters serial mode by writing a serial select bit.
// - Link configures transceiver settings before selecting serial mode.
// - Clock keep-alive bit must be set before entry to keep clock.
// - Exit serial: assert stop, wait direction low, then release stop.
// - Three-pin: link drives data when enable high, PHY otherwise.
module ulm_link (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  output logic CMD_READY,
  input wire logic CFG_PULLUP_DIS,
  input wire logic CFG_KEEPALIVE,
  input wire logic CFG_HOST_OTG,
  input wire logic SER_TX_EN,
  input wire logic SER_TX_DATA,
  input wire logic SER_LINE_DRIVE_ZERO_STATE,
  output logic SER_RX_DATA,
  output logic SER_RX_SE0_N,
  output logic SER_RX_PLUS,
  output logic SER_RX_MINUS,
  output logic SER_INT,
  output logic [2:0] LINK_MODE,
  input wire logic ULPI_DIR,
  input wire logic ULPI_NXT,
  input wire logic [7:0] ULPI_DATA_IN,
  output logic [7:0] ULPI_DATA_OUT,
  output logic [7:0] ULPI_DATA_OE_N,
  output logic ULPI_STP
);
  ulm_rw_if rw ();

  logic dir_m, dir_s, dir_prev, nxt_m, nxt_s;
  logic [7:0] din_m, din_s;
  ulm_pkg::ulm_state_e state_reg, state_next;
  ulm_pkg::ulm_seq_e kind_reg, kind_next;
  logic [2:0] step_reg, step_next;
  logic [7:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic stp_reg, stp_next;
  logic [7:0] dout_reg, dout_next, oe_reg, oe_next;
  logic rxd_reg, rxd_next, se0n_reg, se0n_next;
  logic plus_reg, plus_next, minus_reg, minus_next, int_reg, int_next;
  logic drive_ok, take;
  logic [7:0] ifc_base;
  logic [13:0] word;

  // Interface control base value with protection and keep-alive choices
  function automatic logic [7:0] ifc_cfg(input logic pull_dis, input logic keep);
    logic [7:0] v;
    v = 8'h00;
    v[ulm_pkg::IFC_PULLUP_DIS_BIT] = pull_dis;
    v[ulm_pkg::IFC_KEEPALIVE_BIT] = keep;
    return v;
  endfunction

  // Address and data of one write step of a sequence
  function automatic logic [13:0] seq_word(input ulm_pkg::ulm_seq_e k,
                                           input logic [2:0] s, input logic [7:0] ib);
    logic [13:0] w;
    w = {ulm_pkg::IFC_CTRL_ADDR, ib};
    case (k)
      ulm_pkg::SEQ_LPM: begin
        case (s)
          3'h0: w = {ulm_pkg::HS_COMP_ADDR, ulm_pkg::HS_FAST_STARTUP};
          3'h1: w = {ulm_pkg::IRQ_RISE_ADDR, ulm_pkg::CMP_OFF};
          3'h2: w = {ulm_pkg::IRQ_FALL_ADDR, ulm_pkg::CMP_OFF};
          3'h3: w = {ulm_pkg::CARKIT_IRQ_ADDR, ulm_pkg::ID_OPEN_OFF};
          default: w = {ulm_pkg::FUNC_CTRL_ADDR, ulm_pkg::FUNC_SUSPEND};
        endcase
      end
      ulm_pkg::SEQ_SER3, ulm_pkg::SEQ_SER6: begin
        if (s == 3'h0) begin
          w = {ulm_pkg::FUNC_CTRL_ADDR, ulm_pkg::FUNC_SERIAL};
        end else if (s == 3'h1) begin
          w = {ulm_pkg::IFC_CTRL_ADDR, ib};
        end else if (k == ulm_pkg::SEQ_SER3) begin
          w = {ulm_pkg::IFC_CTRL_ADDR, ib | (8'h01 << ulm_pkg::IFC_SER3_BIT)};
        end else begin
          w = {ulm_pkg::IFC_CTRL_ADDR, ib | (8'h01 << ulm_pkg::IFC_SER6_BIT)};
        end
      end
      ulm_pkg::SEQ_REEN: begin
        if (s == 3'h0) w = {ulm_pkg::IRQ_RISE_ADDR, ulm_pkg::CMP_REENABLE};
        else w = {ulm_pkg::IRQ_FALL_ADDR, ulm_pkg::CMP_REENABLE};
      end
      default: w = {ulm_pkg::IFC_CTRL_ADDR, ib};
    endcase
    return w;
  endfunction

  // Index of the last write step of a sequence
  function automatic logic [2:0] seq_last(input ulm_pkg::ulm_seq_e k);
    case (k)
      ulm_pkg::SEQ_LPM: return 3'h4;
      ulm_pkg::SEQ_SER3, ulm_pkg::SEQ_SER6: return 3'h2;
      ulm_pkg::SEQ_REEN: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  ulm_regwr u_regwr (
    .clk(CLK),
    .rst_n(RESETN),
    .dir(dir_s),
    .nxt(nxt_s),
    .rw(rw)
  );

  assign ifc_base = ifc_cfg(CFG_PULLUP_DIS, CFG_KEEPALIVE);
  assign word = seq_word(kind_reg, step_reg, ifc_base);
  assign rw.start = (state_reg == ulm_pkg::M_SEQ) && !rw.done;
  assign rw.addr = word[13:8];
  assign rw.data = word[7:0];
  assign drive_ok = !dir_s && !dir_prev;
  assign take = CMD_VALID && ready_reg;

  // Pin synchronisers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_m <= 1'b0;
      dir_s <= 1'b0;
      dir_prev <= 1'b0;
      nxt_m <= 1'b0;
      nxt_s <= 1'b0;
      din_m <= 8'h00;
      din_s <= 8'h00;
    end else begin
      dir_m <= ULPI_DIR;
      dir_s <= dir_m;
      dir_prev <= dir_s;
      nxt_m <= ULPI_NXT;
      nxt_s <= nxt_m;
      din_m <= ULPI_DATA_IN;
      din_s <= din_m;
    end
  end

  // Control sequence
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ulm_pkg::M_START: begin
        if (cnt_reg == ulm_pkg::STARTUP_CYC) begin
          state_next = ulm_pkg::M_WAITDIR;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      ulm_pkg::M_WAITDIR: if (!dir_s) state_next = ulm_pkg::M_RELEASE;
      ulm_pkg::M_RELEASE: begin
        step_next = 3'h0;
        if (drive_ok) begin
          state_next = (kind_reg == ulm_pkg::SEQ_NONE) ? ulm_pkg::M_IDLE : ulm_pkg::M_SEQ;
        end
      end
      ulm_pkg::M_SEQ: begin
        if (rw.done) begin
          if (step_reg != seq_last(kind_reg)) begin
            step_next = step_reg + 3'h1;
          end else if (kind_reg == ulm_pkg::SEQ_LPM) begin
            state_next = ulm_pkg::M_LOWPWR;
          end else if (kind_reg == ulm_pkg::SEQ_SER3 || kind_reg == ulm_pkg::SEQ_SER6) begin
            state_next = ulm_pkg::M_SER_WAIT;
          end else begin
            state_next = ulm_pkg::M_IDLE;
          end
        end
      end
      ulm_pkg::M_IDLE: begin
        step_next = 3'h0;
        if (take && CMD_OP != ulm_pkg::CMD_WAKE && CMD_OP <= ulm_pkg::CMD_PROTECT) begin
          state_next = ulm_pkg::M_SEQ;
          unique case (CMD_OP)
            ulm_pkg::CMD_SUSPEND: kind_next = ulm_pkg::SEQ_LPM;
            ulm_pkg::CMD_SER3: kind_next = ulm_pkg::SEQ_SER3;
            ulm_pkg::CMD_SER6: kind_next = ulm_pkg::SEQ_SER6;
            default: kind_next = ulm_pkg::SEQ_PROT;
          endcase
        end
      end
      ulm_pkg::M_SER_WAIT: if (dir_s) state_next = ulm_pkg::M_SERIAL;
      ulm_pkg::M_LOWPWR, ulm_pkg::M_SERIAL: begin
        if (take && CMD_OP == ulm_pkg::CMD_WAKE) begin
          state_next = ulm_pkg::M_WAITDIR;
          kind_next = CFG_HOST_OTG ? ulm_pkg::SEQ_REEN : ulm_pkg::SEQ_NONE;
        end
      end
    endcase
    ready_next = (state_next == ulm_pkg::M_IDLE) || (state_next == ulm_pkg::M_LOWPWR) ||
                 (state_next == ulm_pkg::M_SERIAL);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ulm_pkg::M_START;
      kind_reg <= ulm_pkg::SEQ_PROT;
      step_reg <= 3'h0;
      cnt_reg <= 8'h00;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  // Pin drive
  always_comb begin
    stp_next = 1'b0;
    dout_next = ulm_pkg::BUS_IDLE;
    oe_next = drive_ok ? 8'h00 : ulm_pkg::OE_ALL_OFF;
    unique case (state_reg)
      ulm_pkg::M_START, ulm_pkg::M_WAITDIR: begin
        stp_next = 1'b1;
        oe_next = ulm_pkg::OE_ALL_OFF;
      end
      ulm_pkg::M_RELEASE: stp_next = !drive_ok;
      ulm_pkg::M_SEQ: begin
        stp_next = rw.stp;
        dout_next = rw.drive ? rw.dout : ulm_pkg::BUS_IDLE;
      end
      ulm_pkg::M_IDLE: stp_next = 1'b0;
      ulm_pkg::M_LOWPWR, ulm_pkg::M_SER_WAIT: oe_next = ulm_pkg::OE_ALL_OFF;
      ulm_pkg::M_SERIAL: begin
        oe_next = ulm_pkg::OE_ALL_OFF;
        dout_next[ulm_pkg::SER_TXEN] = SER_TX_EN;
        dout_next[ulm_pkg::SER_TXD] = SER_TX_DATA;
        dout_next[ulm_pkg::SER_SE0] = SER_LINE_DRIVE_ZERO_STATE;
        oe_next[ulm_pkg::SER_TXEN] = 1'b0;
        if (kind_reg == ulm_pkg::SEQ_SER3) begin
          oe_next[ulm_pkg::SER_TXD] = !SER_TX_EN;
          oe_next[ulm_pkg::SER_SE0] = !SER_TX_EN;
        end else begin
          oe_next[ulm_pkg::SER_TXD] = 1'b0;
          oe_next[ulm_pkg::SER_SE0] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stp_reg <= 1'b1;
      dout_reg <= ulm_pkg::BUS_IDLE;
      oe_reg <= ulm_pkg::OE_ALL_OFF;
    end else begin
      stp_reg <= stp_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // Serial receive capture
  always_comb begin
    rxd_next = rxd_reg;
    se0n_next = se0n_reg;
    plus_next = plus_reg;
    minus_next = minus_reg;
    int_next = 1'b0;
    if (state_reg == ulm_pkg::M_SERIAL) begin
      int_next = din_s[ulm_pkg::SER_INT];
      if (kind_reg == ulm_pkg::SEQ_SER3) begin
        if (!SER_TX_EN) begin
          rxd_next = din_s[ulm_pkg::SER_TXD];
          se0n_next = din_s[ulm_pkg::SER_SE0];
        end
      end else begin
        plus_next = din_s[ulm_pkg::SER_PLUS];
        minus_next = din_s[ulm_pkg::SER_MINUS];
        rxd_next = din_s[ulm_pkg::SER_RCV];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rxd_reg <= 1'b0;
      se0n_reg <= 1'b1;
      plus_reg <= 1'b0;
      minus_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      rxd_reg <= rxd_next;
      se0n_reg <= se0n_next;
      plus_reg <= plus_next;
      minus_reg <= minus_next;
      int_reg <= int_next;
    end
  end

  assign CMD_READY = ready_reg;
  assign LINK_MODE = state_reg;
  assign ULPI_STP = stp_reg;
  assign ULPI_DATA_OUT = dout_reg;
  assign ULPI_DATA_OE_N = oe_reg;
  assign SER_RX_DATA = rxd_reg;
  assign SER_RX_SE0_N = se0n_reg;
  assign SER_RX_PLUS = plus_reg;
  assign SER_RX_MINUS = minus_reg;
  assign SER_INT = int_reg;
endmodule

// ===== rtl/ulm_pkg.sv
// Constants and types for the ULPI power and serial mode link controller
package ulm_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LINK_STARTUP_NS = 1000;
  localparam int STARTUP_CYC_INT = (LINK_STARTUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] STARTUP_CYC = 8'(STARTUP_CYC_INT);

  localparam logic [1:0] TXCMD_REGWR = 2'h2;
  localparam logic [7:0] BUS_IDLE = 8'h00;
  localparam logic [7:0] OE_ALL_OFF = 8'hff;

  localparam logic [5:0] FUNC_CTRL_ADDR = 6'h04;
  localparam logic [5:0] IFC_CTRL_ADDR = 6'h07;
  localparam logic [5:0] HS_COMP_ADDR = 6'h31;
  localparam logic [5:0] IRQ_RISE_ADDR = 6'h0d;
  localparam logic [5:0] IRQ_FALL_ADDR = 6'h10;
  localparam logic [5:0] CARKIT_IRQ_ADDR = 6'h1d;

  localparam int IFC_PULLUP_DIS_BIT = 7;
  localparam int IFC_KEEPALIVE_BIT = 3;
  localparam int IFC_SER3_BIT = 1;
  localparam int IFC_SER6_BIT = 0;
  localparam logic [7:0] HS_FAST_STARTUP = 8'h01;
  localparam logic [7:0] FUNC_SERIAL = 8'h49;
  localparam logic [7:0] FUNC_SUSPEND = 8'h09;
  localparam logic [7:0] CMP_OFF = 8'h00;
  localparam logic [7:0] CMP_REENABLE = 8'h0a;
  localparam logic [7:0] ID_OPEN_OFF = 8'h00;

  localparam int SER_TXEN = 0;
  localparam int SER_TXD = 1;
  localparam int SER_SE0 = 2;
  localparam int SER_INT = 3;
  localparam int SER_PLUS = 4;
  localparam int SER_MINUS = 5;
  localparam int SER_RCV = 6;

  typedef enum logic [2:0] {
    CMD_SUSPEND = 3'h0,
    CMD_SER3 = 3'h1,
    CMD_SER6 = 3'h2,
    CMD_WAKE = 3'h3,
    CMD_PROTECT = 3'h4
  } ulm_cmd_e;

  typedef enum logic [2:0] {
    SEQ_NONE = 3'h0,
    SEQ_PROT = 3'h1,
    SEQ_LPM = 3'h2,
    SEQ_SER3 = 3'h3,
    SEQ_SER6 = 3'h4,
    SEQ_REEN = 3'h5
  } ulm_seq_e;

  typedef enum logic [2:0] {
    M_START = 3'h0,
    M_WAITDIR = 3'h1,
    M_RELEASE = 3'h2,
    M_SEQ = 3'h3,
    M_IDLE = 3'h4,
    M_LOWPWR = 3'h5,
    M_SER_WAIT = 3'h6,
    M_SERIAL = 3'h7
  } ulm_state_e;

  typedef enum logic [2:0] {
    W_IDLE = 3'h0,
    W_CMD = 3'h1,
    W_DATA = 3'h2,
    W_STOP = 3'h3,
    W_TURN = 3'h4,
    W_GAP = 3'h5
  } ulm_wr_e;
endpackage

// ===== rtl/ulm_rw_if.sv
// Request and bus signals between the controller and its register writer
interface ulm_rw_if;
  logic start;
  logic [5:0] addr;
  logic [7:0] data;
  logic busy;
  logic done;
  logic drive;
  logic [7:0] dout;
  logic stp;
  modport ctl (output start, addr, data, input busy, done, drive, dout, stp);
  modport wr (input start, addr, data, output busy, done, drive, dout, stp);
endinterface

// ===== rtl/ulm_regwr.sv
// ULPI register write sequencer
module ulm_regwr (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dir,
  input wire logic nxt,
  ulm_rw_if.wr rw
);
  ulm_pkg::ulm_wr_e state_reg;
  ulm_pkg::ulm_wr_e state_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    state_next = state_reg;
    done_next = (state_reg == ulm_pkg::W_STOP);
    unique case (state_reg)
      ulm_pkg::W_IDLE: if (rw.start && !dir) state_next = ulm_pkg::W_CMD;
      ulm_pkg::W_CMD: begin
        if (dir) state_next = ulm_pkg::W_TURN;
        else if (nxt) state_next = ulm_pkg::W_DATA;
      end
      ulm_pkg::W_DATA: begin
        if (dir) state_next = ulm_pkg::W_TURN;
        else if (nxt) state_next = ulm_pkg::W_STOP;
      end
      ulm_pkg::W_STOP: state_next = ulm_pkg::W_IDLE;
      ulm_pkg::W_TURN: if (!dir) state_next = ulm_pkg::W_GAP;
      ulm_pkg::W_GAP: state_next = ulm_pkg::W_CMD;
      default: state_next = ulm_pkg::W_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ulm_pkg::W_IDLE;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg <= done_next;
    end
  end

  assign rw.busy = (state_reg != ulm_pkg::W_IDLE);
  assign rw.done = done_reg;
  assign rw.stp = (state_reg == ulm_pkg::W_STOP);
  assign rw.drive = (state_reg == ulm_pkg::W_CMD) || (state_reg == ulm_pkg::W_DATA) ||
                    (state_reg == ulm_pkg::W_STOP);
  assign rw.dout = (state_reg == ulm_pkg::W_CMD) ? {ulm_pkg::TXCMD_REGWR, rw.addr} :
                   (state_reg == ulm_pkg::W_DATA) ? rw.data : ulm_pkg::BUS_IDLE;
endmodule

// ===== verification/ulm_phy_model.sv
// Behavioural ULPI transceiver answering register writes and mode changes
module ulm_phy_model #(
  parameter int START_CYC = 20
) (
  input wire logic clk,
  input wire logic chip_reset_low,
  input wire logic stp,
  input wire logic [7:0] bus,
  input wire logic plus_line_sense,
  input wire logic minus_line_sense,
  input wire logic bus_power_valid_cmp,
  output logic dir,
  output logic nxt,
  output logic [7:0] phy_out,
  output logic [7:0] phy_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [0:63];
  logic [7:0] cmd;
  logic [7:0] dat;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic turn;
  logic src_sample;
  logic pullup_on;
  logic cmp_on;
  logic int_out;
  int cnt;
  int ph;
  assign pullup_on = chip_reset_low && !regs[7][7];
  assign cmp_on = |((regs[6'h0d] | regs[6'h10]) & 8'h0a);
  assign int_out = cmp_on && (bus_power_valid_cmp != src_sample);
  always_comb begin
    phy_out = 8'h00;
    phy_oe = {8{dir && !turn}};
    if (mode == 2'd1) begin
      phy_out[1:0] = {minus_line_sense, plus_line_sense};
    end
    if (mode != 2'd0) begin
      phy_out[3] = int_out;
    end
    if (mode == 2'd2) begin
      phy_out[2] = plus_line_sense | minus_line_sense;
      phy_out[1] = plus_line_sense & !minus_line_sense;
      phy_oe[2:0] = {{2{dir && !bus[0]}}, 1'b0};
    end
    if (mode == 2'd3) begin
      phy_out[6:4] = {plus_line_sense & !minus_line_sense, minus_line_sense, plus_line_sense};
      phy_oe[2:0] = 3'h0;
    end
  end
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      for (int i = 0; i < 64; i++) begin
        regs[i] <= 8'h00;
      end
      dir <= 1'b1;
      nxt <= 1'b0;
      turn <= 1'b1;
      mode <= 2'd0;
      next_mode <= 2'd0;
      src_sample <= 1'b0;
      cmd <= 8'h00;
      dat <= 8'h00;
      cnt <= 0;
      ph <= 0;
    end else begin
      nxt <= 1'b0;
      turn <= 1'b0;
      case (ph)
        0: begin
          if (mode == 2'd0 || stp) begin
            cnt <= cnt + 1;
          end
          if (cnt == START_CYC) begin
            dir <= 1'b0;
            mode <= 2'd0;
            cnt <= 0;
            ph <= 1;
          end
        end
        1: ph <= stp ? 1 : 2;
        2: if (bus[7:6] == 2'b10) begin
          cmd <= bus;
          nxt <= 1'b1;
          ph <= 3;
        end
        3: if (bus != cmd) begin
          dat <= bus;
          nxt <= 1'b1;
          ph <= 4;
        end
        4: if (stp) begin
          regs[cmd[5:0]] <= dat;
          next_mode <= (cmd[5:0] != 6'h07) ? 2'd1 : (dat[1] ? 2'd2 : 2'd3);
          ph <= ((cmd[5:0] == 6'h04 && !dat[6]) || (cmd[5:0] == 6'h07 && |dat[1:0])) ? 5 : 2;
        end
        default: begin
          dir <= 1'b1;
          turn <= 1'b1;
          mode <= next_mode;
          src_sample <= bus_power_valid_cmp;
          cnt <= 0;
          ph <= 0;
        end
      endcase
    end
  end
endmodule

// ===== verification/ulm_link_checker.sv
// Port assertions for the ULPI link controller
module ulm_link_checker (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic CMD_READY,
  input wire logic SER_TX_EN,
  input wire logic SER_TX_DATA,
  input wire logic SER_LINE_DRIVE_ZERO_STATE,
  input wire logic [2:0] LINK_MODE,
  input wire logic ULPI_DIR,
  input wire logic [7:0] ULPI_DATA_OUT,
  input wire logic [7:0] ULPI_DATA_OE_N,
  input wire logic ULPI_STP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic acc;
  assign acc = CMD_VALID && CMD_READY;
  startup_stop_a: assert property (
    $rose(RESETN) |-> (ULPI_STP && ULPI_DATA_OE_N == 8'hff) [*8])
    else $error("stop or bus not safe after reset");
  dir_release_a: assert property (
    (ULPI_DIR && LINK_MODE < 3'h6) [*4] |-> ULPI_DATA_OE_N == 8'hff)
    else $error("bus driven while direction high");
  turnaround_a: assert property (
    $fell(ULPI_DIR) |-> ULPI_DATA_OE_N == 8'hff [*2])
    else $error("bus driven in turnaround");
  idle_bus_a: assert property (
    LINK_MODE == 3'h4 |-> !ULPI_STP && ULPI_DATA_OUT == 8'h00)
    else $error("idle not driven");
  lowpwr_stop_a: assert property (
    LINK_MODE == 3'h5 && $past(LINK_MODE) == 3'h5 |-> !ULPI_STP && ULPI_DATA_OE_N == 8'hff)
    else $error("low power pins wrong");
  serial_pins_a: assert property (
    LINK_MODE == 3'h7 && $past(LINK_MODE) == 3'h7 |->
    ULPI_DATA_OE_N[7:3] == 5'h1f && !ULPI_DATA_OE_N[0] && !ULPI_STP)
    else $error("serial pin drive wrong");
  serial_tx_a: assert property (
    LINK_MODE == 3'h7 && $past(LINK_MODE) == 3'h7 |->
    ULPI_DATA_OUT[2:0] == $past({SER_LINE_DRIVE_ZERO_STATE, SER_TX_DATA, SER_TX_EN}))
    else $error("serial transmit bits wrong");
  wake_stop_a: assert property (
    acc && CMD_OP == 3'h3 && LINK_MODE inside {3'h5, 3'h7} |-> ##2 ULPI_STP ##1 ULPI_STP)
    else $error("wake without stop");
  accept_a: assert property (
    acc && CMD_OP != 3'h3 && CMD_OP < 3'h5 && LINK_MODE == 3'h4 |=>
    !CMD_READY && LINK_MODE == 3'h3)
    else $error("command not accepted");
  refuse_a: assert property (
    acc && CMD_OP > 3'h4 |=> CMD_READY && $stable(LINK_MODE))
    else $error("bad code acted on");
  cover property (LINK_MODE == 3'h5);
  cover property (LINK_MODE == 3'h7 && ULPI_DATA_OE_N[1]);
  cover property (acc && CMD_OP > 3'h4);
endmodule
bind ulm_link ulm_link_checker chk (.CLK, .RESETN, .CMD_VALID, .CMD_OP, .CMD_READY, .SER_TX_EN,
  .SER_TX_DATA, .SER_LINE_DRIVE_ZERO_STATE, .LINK_MODE, .ULPI_DIR, .ULPI_DATA_OUT, .ULPI_DATA_OE_N, .ULPI_STP);

// ===== verification/test_ulm_link.sv
// Self-checking bench for the ULPI link controller with a transceiver model
module test_ulm_link;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, cmd_valid, pullup_dis, keepalive, host_otg;
  logic tx_en, tx_data, line_drive_zero_state, plus, minus, vbus;
  logic cmd_ready, rx_data, rx_se0_n, rx_plus, rx_minus, ser_int, dir, nxt, stp;
  logic [2:0] cmd_op, link_mode;
  logic [7:0] dout, oe_n, bus, phy_out, phy_oe;
  int miscompares, check_count;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  assign bus = (~oe_n & dout) | (oe_n & phy_oe & phy_out);
  ulm_link uut (.CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_READY(cmd_ready), .CFG_PULLUP_DIS(pullup_dis), .CFG_KEEPALIVE(keepalive),
    .CFG_HOST_OTG(host_otg), .SER_TX_EN(tx_en), .SER_TX_DATA(tx_data), .SER_LINE_DRIVE_ZERO_STATE(line_drive_zero_state),
    .SER_RX_DATA(rx_data), .SER_RX_SE0_N(rx_se0_n), .SER_RX_PLUS(rx_plus),
    .SER_RX_MINUS(rx_minus), .SER_INT(ser_int), .LINK_MODE(link_mode), .ULPI_DIR(dir),
    .ULPI_NXT(nxt), .ULPI_DATA_IN(bus), .ULPI_DATA_OUT(dout), .ULPI_DATA_OE_N(oe_n),
    .ULPI_STP(stp));
  ulm_phy_model phy (.clk(clk), .chip_reset_low(resetn), .stp(stp), .bus(bus),
    .plus_line_sense(plus), .minus_line_sense(minus), .bus_power_valid_cmp(vbus),
    .dir(dir), .nxt(nxt), .phy_out(phy_out), .phy_oe(phy_oe));
  task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 3000 && link_mode !== m; i++) begin
      tick(1);
    end
    if (link_mode !== m) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic send_cmd(input logic [2:0] op);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    @(posedge clk);
    cmd_valid <= 1'b0;
    tick(2);
  endtask
  task automatic sweep(input logic six);
    logic [7:0] seen;
    logic [7:0] exp;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      plus <= k[1];
      minus <= k[0];
      tick(8);
      seen = six ? {5'h0, rx_plus, rx_minus, rx_data} : {6'h0, rx_data, rx_se0_n};
      exp = six ? {5'h0, k[1], k[0], k[1] & !k[0]} : {6'h0, k[1] & !k[0], k[1] | k[0]};
      check_eq(seen, exp);
    end
  endtask
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    pullup_dis = 1'b1;
    keepalive = 1'b1;
    host_otg = 1'b1;
    tx_en = 1'b0;
    tx_data = 1'b0;
    line_drive_zero_state = 1'b0;
    plus = 1'b1;
    minus = 1'b0;
    vbus = 1'b0;
    miscompares = 0;
    check_count = 0;
    tick(8);
    check_eq({stp, oe_n[6:0]}, 8'hff);
    @(posedge clk);
    resetn <= 1'b1;
    wait_mode(3'h4);
    check_eq(phy.regs[7], 8'h88);
    check_eq({7'h0, phy.pullup_on}, 8'h00);
    send_cmd(3'h0);
    wait_mode(3'h5);
    check_eq(phy.regs[6'h31], 8'h01);
    check_eq(phy.regs[6'h0d] | phy.regs[6'h10], 8'h00);
    check_eq(phy.regs[6'h1d], 8'h00);
    check_eq({phy.regs[4][6:0], stp}, 8'h12);
    send_cmd(3'h3);
    wait_mode(3'h4);
    check_eq(phy.regs[6'h0d] & phy.regs[6'h10], 8'h0a);
    check_eq({6'h0, phy.mode}, 8'h00);
    for (int k = 4; k < 8; k++) begin
      send_cmd(k == 4 ? 3'h3 : 3'(k));
      check_eq({cmd_ready, 4'h0, link_mode}, 8'h84);
    end
    send_cmd(3'h1);
    wait_mode(3'h7);
    check_eq(phy.regs[4], 8'h49);
    check_eq(phy.regs[7], 8'h8a);
    sweep(1'b0);
    @(posedge clk);
    tx_en <= 1'b1;
    tx_data <= 1'b1;
    tick(4);
    check_eq(bus, 8'h03);
    @(posedge clk);
    tx_en <= 1'b0;
    vbus <= 1'b1;
    tick(8);
    check_eq({7'h0, ser_int}, 8'h01);
    send_cmd(3'h3);
    wait_mode(3'h4);
    @(posedge clk);
    keepalive <= 1'b0;
    send_cmd(3'h2);
    wait_mode(3'h7);
    check_eq({6'h0, phy.mode}, 8'h03);
    check_eq(phy.regs[7], 8'h81);
    sweep(1'b1);
    check_eq(bus & 8'h80, 8'h00);
    @(posedge clk);
    resetn <= 1'b0;
    tick(8);
    @(posedge clk);
    resetn <= 1'b1;
    wait_mode(3'h4);
    check_eq({6'h0, phy.mode}, 8'h00);
    print_verdict();
  end
endmodule
